// >>> rtl/lsd_pkg.sv
// Purpose: Shared constants and types for the logic slice unit
// Assumes: Four slices per unit, two four-input tables per slice
// Notes: Table contents double as distributed memory storage

package lsd_pkg;
	localparam int NSL = 4;
	localparam int NLUT = 2;
	localparam int NTAB = NSL * NLUT;
	localparam int TAB_BITS = 16;
	localparam int ADDR_W = 4;
	localparam int SEL_W = 3;
	localparam int RAM_LAST_SLICE = 2;
	localparam int CTRL_SLICE = 2;
	localparam int SPR_16X4_SLICES = 3;
	localparam int PSEUDO_DUAL_PORT_MEM_16X4_SLICES = 6;
	localparam logic [1:0] REG_RST = 2'h0;
	localparam logic [1:0] CNT_UP_ADD = 2'h0;
	localparam logic [1:0] CNT_DN_ADD = 2'h3;

	typedef enum logic [1:0] {
		LSD_LOGIC,
		LSD_RIPPLE,
		LSD_RAM,
		LSD_ROM
	} lsd_mode_t;

	typedef enum logic [3:0] {
		LSD_ADD,
		LSD_SUB,
		LSD_ADDSUB,
		LSD_UPCNT,
		LSD_DNCNT,
		LSD_UDCNT_CLR,
		LSD_UDCNT_LOAD,
		LSD_CMP,
		LSD_MULT
	} lsd_rip_t;

	typedef enum logic [1:0] {
		LSD_DRAM_NONE,
		LSD_DRAM_SPR,
		LSD_DRAM_PSEUDO_DUAL_PORT_MEM
	} lsd_dram_t;
endpackage

// >>> rtl/lsd_pfu.sv
// Purpose: One programmable function unit of four logic slices
// Assumes: Table contents loaded through the configuration port
// Notes: Slices 0 and 1 store memory data, slice 2 drives write control

`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Two four-input tables, each feeding one register
// - Memory uses slices 0-2; slice 3 not
// - Register polarity and flop-or-latch selectable
// - Sync/async set-reset, clock select, chip select
// - Fourteen inputs: thirteen routing plus carry in
// - Seven outputs: six routing plus carry out
// - Two inter-slice outputs for wider tables
// - Logic mode: sixteen-entry truth table per table
// - Two tables make five inputs; chain for more
// - Eight-input function needs more than four slices
// - Ripple: 2-bit add, subtract, dynamic add/sub
// - Ripple: 2-bit counters, clear or preload variants
// - Ripple: compare ge/ne/le and multiplier cell
// - Fast carry: per-slice generate and propagate
// - Single-port 16x4 in slices 0 and 1
// - Slice 2 supplies write address and enable
// - Pseudo dual port: read-write plus read-only slice
// - One write updates both companion slices together
// - Memory contents loadable at configuration time
// - 16x4 single port three slices, dual six
// - Read-only mode uses tables in all slices
module lsd_pfu (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [3:0][1:0] i_sl_a,
	input wire logic [3:0][1:0] i_sl_b,
	input wire logic [3:0][1:0] i_sl_c,
	input wire logic [3:0][1:0] i_sl_d,
	input wire logic [3:0][1:0] i_sl_m,
	input wire logic [3:0] i_sl_ce,
	input wire logic [3:0] i_sl_lsr,
	input wire logic [3:0] i_sl_wre,
	input wire logic i_fci,
	input wire logic i_fxin,
	input wire logic i_cfg_we,
	input wire logic [2:0] i_cfg_sel,
	input wire logic [15:0] i_cfg_data,
	input wire lsd_pkg::lsd_mode_t [3:0] i_cfg_mode,
	input wire lsd_pkg::lsd_rip_t [3:0] i_cfg_rip_op,
	input wire lsd_pkg::lsd_dram_t i_cfg_dram,
	input wire logic [3:0] i_cfg_clk_neg,
	input wire logic [3:0] i_cfg_latch,
	input wire logic [3:0] i_cfg_async,
	input wire logic [3:0] i_cfg_srval,
	input wire logic [3:0] i_cfg_dsel,
	output logic [3:0][1:0] o_sl_f,
	output logic [3:0][1:0] o_sl_q,
	output logic [3:0] o_sl_fco,
	output logic o_fco,
	output logic [3:0] o_sl_ofx0,
	output logic [3:0] o_sl_ofx1,
	output logic [3:0] o_sl_gen,
	output logic [3:0] o_sl_prop
);

	////////////////////////////////////////////////////////////////////////////
	// Table storage, shared by logic, ROM and distributed memory
	logic [15:0] tab_q [0:7];
	logic [7:0] ram_we;
	logic [7:0] ram_bit;
	logic [4:0] fci_chain;
	logic [3:0] ofx0;
	logic [3:0] ofx1;
	logic dram_on;
	logic dram_pseudo_dual_port_mem;
	logic [3:0] waddr;

	assign dram_on = (i_cfg_dram != lsd_pkg::LSD_DRAM_NONE);
	assign dram_pseudo_dual_port_mem = (i_cfg_dram == lsd_pkg::LSD_DRAM_PSEUDO_DUAL_PORT_MEM);
	// Write address comes from the control slice's first table inputs
	assign waddr = {i_sl_d[lsd_pkg::CTRL_SLICE][0], i_sl_c[lsd_pkg::CTRL_SLICE][0],
		i_sl_b[lsd_pkg::CTRL_SLICE][0], i_sl_a[lsd_pkg::CTRL_SLICE][0]};
	assign fci_chain[0] = i_fci;
	assign o_fco = fci_chain[lsd_pkg::NSL];

	genvar k;
	generate
		for (k = 0; k < lsd_pkg::NTAB; k++) begin : g_wr
			if (k < 4) begin : g_store
				// Storage tables in slices 0 and 1; write strobe from slice 2
				assign ram_we[k] = dram_on && i_sl_wre[lsd_pkg::CTRL_SLICE];
				// Dual port: slice 1 mirrors slice 0 data on every write
				assign ram_bit[k] = dram_pseudo_dual_port_mem ? i_sl_m[0][k % 2] : i_sl_m[k / 2][k % 2];
			end else begin : g_nostore
				assign ram_we[k] = 1'b0;
				assign ram_bit[k] = 1'b0;
			end
		end
	endgenerate

	// Configuration load wins over a memory write in the same cycle
	always_ff @(posedge i_clock) begin
		if (i_cfg_we) begin
			tab_q[i_cfg_sel] <= i_cfg_data;
		end else begin
			for (int t = 0; t < lsd_pkg::NTAB; t++) begin
				if (ram_we[t]) begin
					tab_q[t][waddr] <= ram_bit[t];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wide table muxes: pairs in slices 0/2, four in slice 1, eight in slice 3
	assign ofx1[0] = i_sl_m[0][1] ? ofx0[1] : ofx0[0];
	assign ofx1[2] = i_sl_m[2][1] ? ofx0[3] : ofx0[2];
	assign ofx1[1] = i_sl_m[1][1] ? ofx1[2] : ofx1[0];
	assign ofx1[3] = i_sl_m[3][1] ? i_fxin : ofx1[1];
	assign o_sl_ofx1 = ofx1;

	////////////////////////////////////////////////////////////////////////////
	// Per-slice datapath and registers
	genvar s;
	generate
		for (s = 0; s < lsd_pkg::NSL; s++) begin : g_sl
			lsd_pkg::lsd_mode_t mode;
			lsd_pkg::lsd_rip_t op;
			logic [3:0] adr0;
			logic [3:0] adr1;
			logic [1:0] tab_f;
			logic [1:0] opa;
			logic [1:0] opb;
			logic [1:0] ax;
			logic [1:0] bx;
			logic [2:0] sum;
			logic [1:0] gbit;
			logic [1:0] pbit;
			logic is_rip;
			logic is_cnt;
			logic is_sub;
			logic cmp_ge;
			logic cmp_ne;
			logic cmp_le;
			logic [1:0] dval;
			logic [1:0] nxt;
			logic [1:0] pos_q;
			logic [1:0] neg_q;
			logic [1:0] held;
			logic [1:0] closing;
			logic transp;

			// Memory mode only reaches slices 0-2; slice 3 falls back to ROM
			assign mode = (dram_on && s <= lsd_pkg::RAM_LAST_SLICE) ? lsd_pkg::LSD_RAM :
				(i_cfg_mode[s] == lsd_pkg::LSD_RAM) ? lsd_pkg::LSD_ROM : i_cfg_mode[s];
			assign op = i_cfg_rip_op[s];
			assign adr0 = {i_sl_d[s][0], i_sl_c[s][0], i_sl_b[s][0], i_sl_a[s][0]};
			assign adr1 = {i_sl_d[s][1], i_sl_c[s][1], i_sl_b[s][1], i_sl_a[s][1]};
			assign tab_f[0] = tab_q[2 * s][adr0];
			assign tab_f[1] = tab_q[2 * s + 1][adr1];
			// Five-input function inside one slice
			assign ofx0[s] = i_sl_m[s][0] ? tab_f[1] : tab_f[0];

			// Ripple operand selection
			assign opa = {i_sl_a[s][1], i_sl_a[s][0]};
			assign opb = {i_sl_b[s][1], i_sl_b[s][0]};
			assign is_rip = (mode == lsd_pkg::LSD_RIPPLE);
			assign is_cnt = (op == lsd_pkg::LSD_UPCNT) || (op == lsd_pkg::LSD_DNCNT) ||
				(op == lsd_pkg::LSD_UDCNT_CLR) || (op == lsd_pkg::LSD_UDCNT_LOAD);
			assign is_sub = (op == lsd_pkg::LSD_SUB) || (op == lsd_pkg::LSD_CMP) ||
				((op == lsd_pkg::LSD_ADDSUB) && !i_sl_m[s][0]);
			assign ax = (op == lsd_pkg::LSD_MULT) ? {i_sl_c[s][1], i_sl_c[s][0]} :
				is_cnt ? held : opa;
			assign bx = (op == lsd_pkg::LSD_MULT) ? (opa & {2{opb[0]}}) :
				(op == lsd_pkg::LSD_UPCNT) ? lsd_pkg::CNT_UP_ADD :
				(op == lsd_pkg::LSD_DNCNT) ? lsd_pkg::CNT_DN_ADD :
				is_cnt ? (i_sl_m[s][0] ? lsd_pkg::CNT_UP_ADD : lsd_pkg::CNT_DN_ADD) :
				is_sub ? ~opb : opb;
			assign sum = {1'b0, ax} + {1'b0, bx} + {2'h0, fci_chain[s]};
			assign gbit = ax & bx;
			assign pbit = ax ^ bx;
			assign o_sl_gen[s] = gbit[1] | (pbit[1] & gbit[0]);
			assign o_sl_prop[s] = pbit[1] & pbit[0];
			assign cmp_ge = sum[2];
			assign cmp_ne = (opa != opb);
			assign cmp_le = !sum[2] || !cmp_ne;
			assign fci_chain[s + 1] = is_rip ? sum[2] : fci_chain[s];
			assign o_sl_fco[s] = fci_chain[s + 1];

			// Routing outputs: compare puts ge/ne on f, le on the inter-slice pin
			assign o_sl_f[s] = !is_rip ? tab_f :
				(op == lsd_pkg::LSD_CMP) ? {cmp_ne, cmp_ge} : sum[1:0];
			assign o_sl_ofx0[s] = (is_rip && op == lsd_pkg::LSD_CMP) ? cmp_le : ofx0[s];

			// Register data: counter state, preload, bypass or table output
			assign dval = (is_rip && op == lsd_pkg::LSD_UDCNT_LOAD && i_sl_m[s][1]) ? opa :
				(is_rip && is_cnt) ? sum[1:0] :
				i_cfg_dsel[s] ? i_sl_m[s] : o_sl_f[s];
			assign nxt = !i_rst_n ? lsd_pkg::REG_RST :
				i_sl_lsr[s] ? {2{i_cfg_srval[s]}} :
				i_sl_ce[s] ? dval : held;

			// One flop per edge; polarity picks the active one
			always_ff @(posedge i_clock) begin
				pos_q <= nxt;
			end
			always_ff @(negedge i_clock) begin
				neg_q <= nxt;
			end

			assign held = i_cfg_clk_neg[s] ? neg_q : pos_q;
			assign closing = i_cfg_clk_neg[s] ? pos_q : neg_q;
			assign transp = (i_clock != i_cfg_clk_neg[s]);
			// Async set-reset overrides the output at once, not at the edge
			assign o_sl_q[s] = (i_cfg_async[s] && i_sl_lsr[s]) ? {2{i_cfg_srval[s]}} :
				i_cfg_latch[s] ? (transp ? nxt : closing) : held;
		end
	endgenerate

endmodule

// >>> test/lsd_pfu_asserts.sv
// Purpose: Output checks for the function unit
// Assumes: Rising-edge flop registers
// Notes: Bound into lsd_pfu
`timescale 1ns/100ps
module lsd_pfu_chk (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [3:0][1:0] i_sl_m,
	input wire logic [3:0] i_sl_ce,
	input wire logic [3:0] i_sl_lsr,
	input wire lsd_pkg::lsd_mode_t [3:0] i_cfg_mode,
	input wire logic [3:0] i_cfg_async,
	input wire logic [3:0] i_cfg_srval,
	input wire logic [3:0] i_cfg_dsel,
	input wire logic [3:0][1:0] o_sl_f,
	input wire logic [3:0][1:0] o_sl_q,
	input wire logic [3:0] o_sl_ofx0,
	input wire logic [3:0] o_sl_ofx1
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	chk_reg_load: assert property (i_sl_ce[2] && i_cfg_dsel[2] && !i_sl_lsr[2]
		|=> o_sl_q[2] == $past(i_sl_m[2])) else $error("reg load");
	chk_reg_hold: assert property (!i_sl_ce[2] && !i_sl_lsr[2] |=> $stable(o_sl_q[2]))
		else $error("reg hold");
	chk_sync_sr: assert property (i_sl_lsr[2] && !i_cfg_async[2]
		|=> o_sl_q[2] == {2{$past(i_cfg_srval[2])}}) else $error("sync set");
	chk_async_sr: assert property (i_cfg_async[3] && i_sl_lsr[3] |-> o_sl_q[3] == {2{i_cfg_srval[3]}})
		else $error("async set");
	chk_five_mux: assert property (i_cfg_mode[3] != lsd_pkg::LSD_RIPPLE
		|-> o_sl_ofx0[3] == (i_sl_m[3][0] ? o_sl_f[3][1] : o_sl_f[3][0])) else $error("five mux");
	chk_six_low: assert property (o_sl_ofx1[0] == (i_sl_m[0][1] ? o_sl_ofx0[1] : o_sl_ofx0[0]))
		else $error("six low");
	chk_six_high: assert property (o_sl_ofx1[2] == (i_sl_m[2][1] ? o_sl_ofx0[3] : o_sl_ofx0[2]))
		else $error("six high");
	chk_seven_mux: assert property (o_sl_ofx1[1] == (i_sl_m[1][1] ? o_sl_ofx1[2] : o_sl_ofx1[0]))
		else $error("seven mux");
endmodule
bind lsd_pfu lsd_pfu_chk u_chk (.*);

// >>> test/lsd_fabric.sv
// Purpose: Fabric model issuing memory writes
// Assumes: Request taken on the falling edge
// Notes: Released lines show the inverse value
`timescale 1ns/100ps
module lsd_fabric (
	input wire logic i_clock,
	input wire logic i_go,
	input wire logic [3:0] i_addr,
	input wire logic [3:0] i_data,
	output logic o_wre = 1'b0,
	output logic [3:0] o_addr = 4'h0,
	output logic [3:0] o_data = 4'h0
);
	always @(negedge i_clock) begin
		o_wre <= i_go;
		o_addr <= i_go ? i_addr : ~o_addr;
		o_data <= i_go ? i_data : ~o_data;
	end
endmodule

// >>> test/tb_logic_slice_distributed_ram.sv
// Purpose: Self-checking bench for the function unit
// Assumes: Rising-edge flop registers
// Notes: Driver queues expectations, monitor checks them
`timescale 1ns/100ps
module tb_logic_slice_distributed_ram;
	logic i_clock = 1'b0, i_rst_n = 1'b0, i_fci = 1'b0, i_fxin = 1'b0, i_cfg_we = 1'b0, go = 1'b0;
	logic [3:0][1:0] a = 8'h0, b = 8'h0, c = 8'h0, d = 8'h0, tm = 8'h0, o_sl_f, o_sl_q;
	logic [3:0] i_sl_ce = 4'h0, i_sl_lsr = 4'h0, i_cfg_clk_neg = 4'h0, i_cfg_latch = 4'h0, fa = 4'h0;
	logic [3:0] i_cfg_async = 4'h8, i_cfg_srval = 4'h4, i_cfg_dsel = 4'h4, fd = 4'h0;
	logic [3:0] o_sl_fco, o_sl_ofx0, o_sl_ofx1, o_sl_gen, o_sl_prop, mem [4];
	logic [2:0] i_cfg_sel = 3'h0, r;
	logic [15:0] i_cfg_data = 16'h0, tab [8];
	logic [9:0] nq[$], e;
	logic [7:0] v, x, qm = 8'h0;
	logic o_fco, w_we;
	logic [3:0] w_a, w_d;
	lsd_pkg::lsd_mode_t [3:0] i_cfg_mode;
	lsd_pkg::lsd_rip_t [3:0] i_cfg_rip_op;
	lsd_pkg::lsd_dram_t i_cfg_dram = lsd_pkg::LSD_DRAM_NONE;
	int num_errors = 0, n_checks = 0;
	wire [3:0] i_sl_wre = {1'b0, w_we, 2'h0};
	wire [3:0][1:0] i_sl_a = {a[3], a[2][1], w_a[0], a[1:0]};
	wire [3:0][1:0] i_sl_b = {b[3], b[2][1], w_a[1], b[1:0]};
	wire [3:0][1:0] i_sl_c = {c[3], c[2][1], w_a[2], c[1:0]};
	wire [3:0][1:0] i_sl_d = {d[3], d[2][1], w_a[3], d[1:0]};
	wire [3:0][1:0] i_sl_m = {tm[3:2], w_d};
	lsd_fabric u_fab (.i_clock(i_clock), .i_go(go), .i_addr(fa), .i_data(fd), .o_wre(w_we), .o_addr(w_a), .o_data(w_d));
	lsd_pfu u_dut (.*);
	initial forever #10 i_clock = ~i_clock;
	function automatic logic [7:0] fexp();
		logic [7:0] t;
		for (int k = 0; k < 8; k++)
			t[k] = tab[k][{i_sl_d[k/2][k%2], i_sl_c[k/2][k%2], i_sl_b[k/2][k%2], i_sl_a[k/2][k%2]}];
		return t;
	endfunction
	task automatic note(input logic [1:0] s, input logic [7:0] ev);
		nq.push_back({s, ev});
		@(negedge i_clock);
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge i_clock) begin
		#5;
		if (nq.size() > 0) begin
			e = nq.pop_front();
			v = e[9:8] == 2'h1 ? o_sl_q : o_sl_f;
			if (e[9:8] == 2'h2)
				v[5:4] = 2'h0;
			if (e[9:8] == 2'h3)
				v = {3'h0, o_sl_gen[3], o_sl_prop[3], o_fco, o_sl_f[3]};
			check(e[9:8] == 2'h3 ? "ripple" : e[9:8] == 2'h2 ? "memory" : e[9:8] == 2'h1 ? "register" : "table", v, e[7:0]);
		end
	end
	// Run needs about 74 cycles
	initial begin
		#50000;
		num_errors++;
		finish_test();
	end
	initial begin
		for (int k = 0; k < 4; k++) begin
			i_cfg_mode[k] = lsd_pkg::LSD_LOGIC;
			i_cfg_rip_op[k] = lsd_pkg::LSD_ADD;
		end
		void'($urandom(32'h71ed));
		repeat (10) @(negedge i_clock);
		i_rst_n = 1'b1;
		i_cfg_mode[3] = lsd_pkg::LSD_ROM;
		i_cfg_we = 1'b1;
		for (int k = 0; k < 8; k++) begin
			tab[k] = 16'($urandom);
			i_cfg_sel = 3'(k);
			i_cfg_data = tab[k];
			@(negedge i_clock);
		end
		i_cfg_we = 1'b0;
		for (int k = 0; k < 24; k++) begin
			{a, b, c, d} = $urandom;
			{tm, i_fxin} = 9'($urandom);
			{i_sl_ce, i_sl_lsr} = k > 7 ? 8'($urandom) & 8'hcc : 8'h0;
			#1;
			x = fexp();
			qm[5:4] = i_sl_lsr[2] ? 2'h3 : i_sl_ce[2] ? tm[2] : qm[5:4];
			qm[7:6] = i_sl_lsr[3] ? 2'h0 : i_sl_ce[3] ? x[7:6] : qm[7:6];
			note(k > 7 ? 2'h1 : 2'h0, k > 7 ? qm : x);
		end
		{i_sl_ce, i_sl_lsr} = 8'h0;
		i_cfg_dram = lsd_pkg::LSD_DRAM_SPR;
		go <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			mem[k] = 4'($urandom);
			fa <= 4'(k);
			fd <= mem[k];
			@(negedge i_clock);
		end
		go <= 1'b0;
		repeat (2) @(negedge i_clock);
		for (int k = 0; k < 4; k++) begin
			{a[1:0], b[1:0], c[1:0], d[1:0]} = {{4{k[0]}}, {4{k[1]}}, 8'h0};
			x = fexp();
			note(2'h2, {x[7:6], 2'h0, mem[k]});
		end
		i_cfg_dram = lsd_pkg::LSD_DRAM_PSEUDO_DUAL_PORT_MEM;
		go <= 1'b1;
		fa <= 4'h9;
		mem[0] = 4'($urandom);
		fd <= mem[0];
		@(negedge i_clock);
		go <= 1'b0;
		repeat (2) @(negedge i_clock);
		{a[1:0], b[1:0], c[1:0], d[1:0]} = 16'hf00f;
		x = fexp();
		note(2'h2, {x[7:6], 2'h0, {2{mem[0][1:0]}}});
		i_cfg_dram = lsd_pkg::LSD_DRAM_NONE;
		i_cfg_mode[3] = lsd_pkg::LSD_RIPPLE;
		for (int k = 0; k < 16; k++) begin
			i_cfg_rip_op[3] = k[3] ? lsd_pkg::LSD_SUB : lsd_pkg::LSD_ADD;
			{a[3], b[3], i_fci} = 5'($urandom);
			x[1:0] = k[3] ? ~b[3] : b[3];
			r = {1'b0, a[3]} + {1'b0, x[1:0]} + {2'h0, i_fci};
			note(2'h3, {3'h0, (x[1] & a[3][1]) | ((x[1] ^ a[3][1]) & x[0] & a[3][0]), &(a[3] ^ x[1:0]), r});
		end
		repeat (2) @(negedge i_clock);
		finish_test();
	end
endmodule
